// file: design/hvio_pkg.sv
// constants and carrier types for the high voltage pin protection and status block
package hvio_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;

  // times in their printed units
  localparam int unsigned SHORT_FAST_US = 20;
  localparam int unsigned SHORT_WAKE_US = 400;
  localparam int unsigned SER_LAT_US = 10;
  localparam int unsigned WAKE_TIMEOUT_MS = 1300;

  // cycle counts at the clock rate (least times round up, rates divide evenly here)
  localparam int unsigned SHORT_FAST_CYC = SHORT_FAST_US * CLK_PER_US;
  localparam int unsigned SHORT_WAKE_CYC = SHORT_WAKE_US * CLK_PER_US;
  localparam int unsigned SER_LAT_CYC = SER_LAT_US * CLK_PER_US;
  localparam int unsigned WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_MS * CLK_PER_MS;
  localparam int unsigned LAT_W = 8;

  // register selects on the command port
  localparam logic [1:0] SEL_CFG_ZERO = 2'h0;
  localparam logic [1:0] SEL_CFG_ONE = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_MONITOR = 2'h3;

  // reset values
  localparam logic [7:0] CFG_ZERO_RST = 8'h00;
  localparam logic [7:0] CFG_ONE_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // hv_config_one fields
  localparam int unsigned C1_PULLUP = 0;
  localparam int unsigned C1_TMO_DIS = 1;
  localparam int unsigned C1_PASSIVE = 2;
  localparam int unsigned C1_REENABLE = 3;
  localparam int unsigned C1_IN_EN = 4;

  // hv_config_zero fields
  localparam int unsigned C0_UV_EN = 3;
  localparam int unsigned C0_WAKE = 4;
  localparam int unsigned C0_TSD_OFF = 7;

  // hv_event_status fields
  localparam int unsigned ST_WAKE_SC = 0;
  localparam int unsigned ST_TEST_SC = 1;
  localparam int unsigned ST_BUS_SC = 2;
  localparam int unsigned ST_THERMAL = 3;
  localparam int unsigned ST_WAKE_EDGE = 4;
  localparam int unsigned ST_UV = 5;

  // hv_level_monitor fields
  localparam int unsigned MON_WAKE_SC = 0;
  localparam int unsigned MON_TEST_SC = 1;
  localparam int unsigned MON_BUS_SC = 2;
  localparam int unsigned MON_THERMAL = 3;
  localparam int unsigned MON_UV = 4;
  localparam int unsigned MON_TEST_LVL = 5;
  localparam int unsigned MON_WAKE_LVL = 7;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] sel;
    logic [7:0] data;
  } hvio_cmd_t;

  typedef struct packed {
    logic wakeLvl;
    logic testLvl;
    logic busShort;
    logic testShort;
    logic wakeShort;
    logic thermal;
    logic underVolt;
  } hvio_sense_t;
endpackage

// file: design/hvio_sync2.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/100ps
module hvio_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  generate
    if (W < 1) begin : gChk
      $error("hvio_sync2 needs W >= 1");
    end
    for (genvar i = 0; i < W; i++) begin : gBit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= d[i];
          stable_q <= meta_q;
        end
      end
      assign q[i] = stable_q;
    end
  endgenerate
endmodule

// file: design/hvio_persist.sv
// persistence filter: reports a level only after it has held COUNT cycles
`timescale 1ns/100ps
module hvio_persist #(
  parameter int unsigned COUNT = 400
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw condition and filtered detect
  input wire logic level,
  output logic detect_q
);
  localparam int unsigned CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic detect_d;

  generate
    if (COUNT < 1) begin : gChk
      $error("hvio_persist needs COUNT >= 1");
    end
  endgenerate

  always_comb begin
    cnt_d = cnt_q;
    detect_d = detect_q;
    if (!level) begin
      cnt_d = '0;
      detect_d = 1'b0;
    end else if (cnt_q == CW'(COUNT - 1)) begin
      detect_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      detect_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      detect_q <= detect_d;
    end
  end
endmodule

// file: design/hvio_protect_status.sv
// protection, status and wake pin control for the high voltage pins
`timescale 1ns/100ps
module hvio_protect_status #(
  parameter int unsigned WAKE_SHORT_CYC = hvio_pkg::SHORT_WAKE_CYC,
  parameter int unsigned WAKE_TIMEOUT_CYC = hvio_pkg::WAKE_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial command port and data port
  input wire hvio_pkg::hvio_cmd_t cmd,
  output logic cmdBusy_q,
  output logic cmdAck_q,
  output logic [7:0] dataPort_q,
  // raw pin sense and analog comparators
  input wire hvio_pkg::hvio_sense_t sense,
  // wake pin drive
  output logic wakePinOut_q,
  output logic wakePinOeN_q,
  output logic wakePullup_q,
  // driver enables and configuration to analog
  output logic busDrvOn_q,
  output logic testDrvOn_q,
  output logic [7:0] cfgZero_q,
  output logic [7:0] cfgOne_q,
  // interrupt line
  output logic hvIrq_q
);
  localparam int unsigned TMO_W = $clog2(WAKE_TIMEOUT_CYC + 1);
  localparam int SER_DLY = hvio_pkg::SER_LAT_CYC;

  generate
    if (WAKE_SHORT_CYC < 1 || WAKE_TIMEOUT_CYC < 2 || hvio_pkg::SER_LAT_CYC < 2) begin : gChk
      $error("hvio_protect_status counts too small");
    end
  endgenerate

  typedef enum logic {HVIO_IDLE, HVIO_WAIT} hvio_state_t;

  hvio_pkg::hvio_sense_t syn;
  logic busDet, testDet, wakeDet;

  hvio_sync2 #(.W(7)) uSync (.clk(clk), .rst(rst), .d(sense), .q(syn));
  hvio_persist #(.COUNT(hvio_pkg::SHORT_FAST_CYC)) uBusSc (
    .clk(clk), .rst(rst), .level(syn.busShort), .detect_q(busDet));
  hvio_persist #(.COUNT(hvio_pkg::SHORT_FAST_CYC)) uTestSc (
    .clk(clk), .rst(rst), .level(syn.testShort), .detect_q(testDet));
  hvio_persist #(.COUNT(WAKE_SHORT_CYC)) uWakeSc (
    .clk(clk), .rst(rst), .level(syn.wakeShort), .detect_q(wakeDet));

  hvio_state_t state_q, state_d;
  hvio_pkg::hvio_cmd_t pend_q, pend_d;
  logic [hvio_pkg::LAT_W-1:0] latCnt_q, latCnt_d;
  logic [TMO_W-1:0] tmoCnt_q, tmoCnt_d;
  logic [7:0] cfgZero_d, cfgOne_d, dataPort_d;
  logic cmdBusy_d, cmdAck_d, hvIrq_d;
  logic wakePinOut_d, wakePinOeN_d, wakePullup_d;
  logic busDrvOn_d, testDrvOn_d, wakeDrvOn_q, wakeDrvOn_d;
  logic wakeSc_q, wakeSc_d, testSc_q, testSc_d, busSc_q, busSc_d;
  logic thermal_q, thermal_d, wakeEdge_q, wakeEdge_d;
  logic shortPend_q, shortPend_d, otherPend_q, otherPend_d;
  logic wakePrev_q, testPrev_q, busDetPrev_q, testDetPrev_q, wakeDetPrev_q;
  logic thermPrev_q, uvPrev_q;
  logic inEn, uvOn, edgeWake, edgeTest, busEvt, testEvt, wakeEvt, thermEvt, uvEvt;
  logic anyEvt, reWrite, rdStatus;
  logic [7:0] statusNow, statusNext, monitorNow;

  always_comb begin
    inEn = cfgOne_q[hvio_pkg::C1_IN_EN];
    uvOn = syn.underVolt & cfgZero_q[hvio_pkg::C0_UV_EN];
    edgeWake = inEn & (syn.wakeLvl ^ wakePrev_q);
    edgeTest = inEn & (syn.testLvl ^ testPrev_q);
    busEvt = busDet & ~busDetPrev_q;
    testEvt = testDet & ~testDetPrev_q;
    wakeEvt = wakeDet & ~wakeDetPrev_q;
    thermEvt = syn.thermal & ~thermPrev_q;
    uvEvt = uvOn & ~uvPrev_q;
    anyEvt = edgeWake | edgeTest | busEvt | testEvt | wakeEvt | thermEvt | uvEvt;
    statusNow = {2'b00, uvOn, wakeEdge_q, thermal_q, busSc_q, testSc_q, wakeSc_q};
    monitorNow = '0;
    monitorNow[hvio_pkg::MON_WAKE_LVL] = syn.wakeLvl & inEn;
    monitorNow[hvio_pkg::MON_TEST_LVL] = syn.testLvl & inEn;
    monitorNow[hvio_pkg::MON_UV] = uvOn;
    monitorNow[hvio_pkg::MON_THERMAL] = syn.thermal;
    monitorNow[hvio_pkg::MON_BUS_SC] = busDet;
    monitorNow[hvio_pkg::MON_TEST_SC] = testDet;
    monitorNow[hvio_pkg::MON_WAKE_SC] = wakeDet;

    state_d = state_q;
    pend_d = pend_q;
    latCnt_d = latCnt_q;
    tmoCnt_d = tmoCnt_q;
    cfgZero_d = cfgZero_q;
    cfgOne_d = cfgOne_q;
    dataPort_d = dataPort_q;
    cmdAck_d = 1'b0;
    busDrvOn_d = busDrvOn_q;
    testDrvOn_d = testDrvOn_q;
    wakeDrvOn_d = wakeDrvOn_q;
    wakeSc_d = wakeSc_q;
    testSc_d = testSc_q;
    busSc_d = busSc_q;
    thermal_d = thermal_q;
    wakeEdge_d = wakeEdge_q;
    shortPend_d = shortPend_q;
    otherPend_d = otherPend_q;
    reWrite = 1'b0;
    rdStatus = 1'b0;

    // timeout runs first so a same-cycle write of the wake bit wins
    if (cfgZero_q[hvio_pkg::C0_WAKE] && !cfgOne_q[hvio_pkg::C1_TMO_DIS]) begin
      if (tmoCnt_q == TMO_W'(WAKE_TIMEOUT_CYC - 1)) begin
        cfgZero_d[hvio_pkg::C0_WAKE] = 1'b0;
        tmoCnt_d = '0;
      end else begin
        tmoCnt_d = tmoCnt_q + 1'b1;
      end
    end else begin
      tmoCnt_d = '0;
    end

    // command port: every access completes after the serial latency
    unique case (state_q)
      HVIO_IDLE: begin
        if (cmd.valid) begin
          pend_d = cmd;
          latCnt_d = hvio_pkg::LAT_W'(hvio_pkg::SER_LAT_CYC - 2);
          state_d = HVIO_WAIT;
        end
      end
      HVIO_WAIT: begin
        if (latCnt_q != '0) begin
          latCnt_d = latCnt_q - 1'b1;
        end else begin
          state_d = HVIO_IDLE;
          cmdAck_d = 1'b1;
          if (pend_q.write) begin
            if (pend_q.sel == hvio_pkg::SEL_CFG_ZERO) begin
              cfgZero_d = pend_q.data;
            end else if (pend_q.sel == hvio_pkg::SEL_CFG_ONE) begin
              cfgOne_d = pend_q.data;
              cfgOne_d[hvio_pkg::C1_REENABLE] = 1'b0;
              reWrite = pend_q.data[hvio_pkg::C1_REENABLE];
            end
          end else begin
            rdStatus = (pend_q.sel == hvio_pkg::SEL_STATUS);
            unique case (pend_q.sel)
              hvio_pkg::SEL_CFG_ZERO: dataPort_d = cfgZero_q;
              hvio_pkg::SEL_CFG_ONE: dataPort_d = cfgOne_q;
              hvio_pkg::SEL_STATUS: dataPort_d = statusNow;
              hvio_pkg::SEL_MONITOR: dataPort_d = monitorNow;
            endcase
          end
        end
      end
    endcase

    // clears first, then sets, so a same-cycle event is kept
    if (rdStatus) begin
      busSc_d = 1'b0;
      testSc_d = 1'b0;
      wakeEdge_d = 1'b0;
      otherPend_d = 1'b0;
    end
    if (reWrite) begin
      busDrvOn_d = 1'b1;
      testDrvOn_d = 1'b1;
      wakeDrvOn_d = 1'b1;
      shortPend_d = 1'b0;
      busSc_d = 1'b0;
      wakeSc_d = 1'b0;
      thermal_d = 1'b0;
    end
    if (edgeWake) begin
      wakeEdge_d = 1'b1;
    end
    if (edgeWake || edgeTest || thermEvt || uvEvt) begin
      otherPend_d = 1'b1;
    end
    if (thermEvt) begin
      thermal_d = 1'b1;
      if (!cfgZero_q[hvio_pkg::C0_TSD_OFF]) begin
        busDrvOn_d = 1'b0;
        testDrvOn_d = 1'b0;
        wakeDrvOn_d = 1'b0;
      end
    end
    if (busEvt) begin
      busSc_d = 1'b1;
      shortPend_d = 1'b1;
      if (!cfgOne_q[hvio_pkg::C1_PASSIVE]) begin
        busDrvOn_d = 1'b0;
      end
    end
    if (testEvt) begin
      testSc_d = 1'b1;
      shortPend_d = 1'b1;
      testDrvOn_d = 1'b0;
    end
    if (wakeEvt) begin
      wakeSc_d = 1'b1;
      shortPend_d = 1'b1;
      wakeDrvOn_d = 1'b0;
    end

    statusNext = {2'b00, uvOn, wakeEdge_d, thermal_d, busSc_d, testSc_d, wakeSc_d};
    // the snapshot overrides a read finishing in the same cycle
    if (anyEvt) begin
      dataPort_d = statusNext;
    end
    hvIrq_d = shortPend_d | otherPend_d;
    wakePinOut_d = cfgZero_d[hvio_pkg::C0_WAKE] & wakeDrvOn_d;
    wakePinOeN_d = ~wakePinOut_d;
    wakePullup_d = cfgOne_d[hvio_pkg::C1_PULLUP];
    cmdBusy_d = (state_d == HVIO_WAIT);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= HVIO_IDLE;
      pend_q <= '0;
      latCnt_q <= '0;
      tmoCnt_q <= '0;
      cfgZero_q <= hvio_pkg::CFG_ZERO_RST;
      cfgOne_q <= hvio_pkg::CFG_ONE_RST;
      dataPort_q <= hvio_pkg::STATUS_RST;
      cmdAck_q <= 1'b0;
      cmdBusy_q <= 1'b0;
      hvIrq_q <= 1'b0;
      busDrvOn_q <= 1'b1;
      testDrvOn_q <= 1'b1;
      wakeDrvOn_q <= 1'b1;
      wakePinOut_q <= 1'b0;
      wakePinOeN_q <= 1'b1;
      wakePullup_q <= 1'b0;
      {wakeSc_q, testSc_q, busSc_q, thermal_q, wakeEdge_q} <= '0;
      {shortPend_q, otherPend_q} <= '0;
      {wakePrev_q, testPrev_q, busDetPrev_q, testDetPrev_q} <= '0;
      {wakeDetPrev_q, thermPrev_q, uvPrev_q} <= '0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      latCnt_q <= latCnt_d;
      tmoCnt_q <= tmoCnt_d;
      cfgZero_q <= cfgZero_d;
      cfgOne_q <= cfgOne_d;
      dataPort_q <= dataPort_d;
      cmdAck_q <= cmdAck_d;
      cmdBusy_q <= cmdBusy_d;
      hvIrq_q <= hvIrq_d;
      busDrvOn_q <= busDrvOn_d;
      testDrvOn_q <= testDrvOn_d;
      wakeDrvOn_q <= wakeDrvOn_d;
      wakePinOut_q <= wakePinOut_d;
      wakePinOeN_q <= wakePinOeN_d;
      wakePullup_q <= wakePullup_d;
      {wakeSc_q, testSc_q, busSc_q, thermal_q, wakeEdge_q} <=
        {wakeSc_d, testSc_d, busSc_d, thermal_d, wakeEdge_d};
      {shortPend_q, otherPend_q} <= {shortPend_d, otherPend_d};
      {wakePrev_q, testPrev_q, busDetPrev_q, testDetPrev_q} <=
        {syn.wakeLvl, syn.testLvl, busDet, testDet};
      {wakeDetPrev_q, thermPrev_q, uvPrev_q} <= {wakeDet, syn.thermal, uvOn};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sAccept;
    (state_q == HVIO_IDLE) && cmd.valid;
  endsequence
  sequence sAckAfterLat;
    (!cmdAck_q) [*2] ##(SER_DLY - 2) cmdAck_q;
  endsequence

  AST_EDGE_IRQ: assert property (edgeWake |=> hvIrq_q && wakeEdge_q)
    else $error("wake edge did not raise interrupt");
  AST_SER_LAT: assert property (sAccept |-> ##1 sAckAfterLat)
    else $error("command did not complete after serial latency");
  AST_PEND_HOLD: assert property (shortPend_q && !reWrite |=> hvIrq_q && shortPend_q)
    else $error("short interrupt cleared without re-enable");
  AST_THERM_OFF: assert property (!testDrvOn_q && !reWrite |=> !testDrvOn_q)
    else $error("test driver came back without re-enable");
  AST_PASSIVE: assert property (busEvt && cfgOne_q[hvio_pkg::C1_PASSIVE] && busDrvOn_q
    && !thermEvt |=> busDrvOn_q && busSc_q && hvIrq_q)
    else $error("passive mode disabled bus driver");
  AST_ACTIVE: assert property (busEvt && !cfgOne_q[hvio_pkg::C1_PASSIVE]
    |=> !busDrvOn_q && busSc_q)
    else $error("active mode kept bus driver on");
  AST_TIMEOUT: assert property (tmoCnt_q == TMO_W'(WAKE_TIMEOUT_CYC - 1)
    && !cfgOne_q[hvio_pkg::C1_TMO_DIS] && !cmdAck_d |=> !wakePinOut_q)
    else $error("wake output not dropped at timeout");
  // compared against the flags as registered, not the expression that loads the port
  AST_SNAPSHOT: assert property (anyEvt |=> dataPort_q == {2'h0, $past(uvOn), wakeEdge_q,
    thermal_q, busSc_q, testSc_q, wakeSc_q})
    else $error("status not copied into data port");
  AST_BUS_RDCLR: assert property (rdStatus && !busEvt |=> !busSc_q)
    else $error("bus short flag survived status read");
  AST_WAKE_SC: assert property (wakeEvt |=> wakeSc_q && hvIrq_q && !wakePinOut_q)
    else $error("wake short not handled");
  AST_PULLUP: assert property (cmdAck_q && $past(pend_q.write)
    && $past(pend_q.sel) == hvio_pkg::SEL_CFG_ONE
    |-> wakePullup_q == $past(pend_q.data[hvio_pkg::C1_PULLUP]))
    else $error("pull-up does not follow config bit");
endmodule

// file: verif/hvio_pin_model.sv
// behavioural model of the high voltage pins and analog sense beyond the block
`timescale 1ns/100ps
module hvio_pin_model (
  // driver state from the block
  input wire logic wakePinOut_q,
  input wire logic wakePinOeN_q,
  input wire logic busDrvOn_q,
  input wire logic testDrvOn_q,
  // external levels; faults are bus, test, wake short, thermal, undervoltage
  input wire logic extWake,
  input wire logic extTest,
  input wire logic [4:0] fault,
  // sensed levels
  output hvio_pkg::hvio_sense_t sense
);
  logic wakeDrv;

  assign wakeDrv = wakePinOut_q & ~wakePinOeN_q;
  // wake bus has a pull-down; a short only draws current while its driver is on
  assign sense = {wakeDrv | extWake, extTest, fault[4] & busDrvOn_q,
    fault[3] & testDrvOn_q, fault[2] & wakeDrv, fault[1], fault[0]};
endmodule

// file: verif/hvio_protect_status_tb.sv
// self-checking bench for the high voltage protection and status block
`timescale 1ns/100ps
module hvio_protect_status_tb;
  // short counts keep the run brief
  localparam int WSC = 8;
  localparam int WTO = 50;
  localparam logic [1:0] SC0 = hvio_pkg::SEL_CFG_ZERO;
  localparam logic [1:0] SC1 = hvio_pkg::SEL_CFG_ONE;
  localparam logic [1:0] SST = hvio_pkg::SEL_STATUS;
  localparam logic [1:0] SMN = hvio_pkg::SEL_MONITOR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  hvio_pkg::hvio_cmd_t cmd = '0;
  hvio_pkg::hvio_sense_t sense;
  logic cmdBusy_q, cmdAck_q, wakePinOut_q, wakePinOeN_q, wakePullup_q;
  logic busDrvOn_q, testDrvOn_q, hvIrq_q;
  logic [7:0] dataPort_q, cfgZero_q, cfgOne_q, d;
  logic extWake = 1'b0;
  logic extTest = 1'b0;
  logic [4:0] fault = 5'h00;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  // model of both config registers and the status byte
  logic [7:0] m0 = 8'h00;
  logic [7:0] m1 = 8'h00;
  logic [7:0] mst = 8'h00;

  always #25 clk = ~clk;

  hvio_protect_status #(.WAKE_SHORT_CYC(WSC), .WAKE_TIMEOUT_CYC(WTO)) u_dut (
    .clk(clk), .rst(rst), .cmd(cmd), .cmdBusy_q(cmdBusy_q), .cmdAck_q(cmdAck_q),
    .dataPort_q(dataPort_q), .sense(sense), .wakePinOut_q(wakePinOut_q),
    .wakePinOeN_q(wakePinOeN_q), .wakePullup_q(wakePullup_q), .busDrvOn_q(busDrvOn_q),
    .testDrvOn_q(testDrvOn_q), .cfgZero_q(cfgZero_q), .cfgOne_q(cfgOne_q), .hvIrq_q(hvIrq_q)
  );

  hvio_pin_model u_pins (
    .wakePinOut_q(wakePinOut_q), .wakePinOeN_q(wakePinOeN_q), .busDrvOn_q(busDrvOn_q),
    .testDrvOn_q(testDrvOn_q), .extWake(extWake), .extTest(extTest), .fault(fault),
    .sense(sense)
  );

  function automatic logic [7:0] drv();
    return {6'h00, busDrvOn_q, testDrvOn_q};
  endfunction

  function automatic logic [7:0] wk();
    return {6'h00, wakePinOut_q, wakePinOeN_q};
  endfunction

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // entered at a falling edge; request held until the ack edge
  task automatic hv(input logic wr, input logic [1:0] sel, input logic [7:0] dat);
    int n;
    logic w0;
    n = 0;
    w0 = wakePinOut_q;
    cmd = '{1'b1, wr, sel, dat};
    do begin
      @(negedge clk);
      n++;
      if (cmdAck_q !== 1'b1) begin
        chk("wakeEarly", {7'h00, w0}, {7'h00, wakePinOut_q});
        chk("busy", 8'h01, {7'h00, cmdBusy_q});
      end
    end while (cmdAck_q !== 1'b1 && n < 300);
    cmd.valid = 1'b0;
    chk("ackTime", 8'hC8, n[7:0]);
    chk("busy", 8'h00, {7'h00, cmdBusy_q});
    // let an edge pass so valid is never raised where it was just lowered
    @(negedge clk);
    chk("ackLen", 8'h00, {7'h00, cmdAck_q});
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] dat);
    hv(1'b1, sel, dat);
    if (sel == SC0) m0 = dat;
    if (sel == SC1) m1 = dat & 8'hF7;
    if (sel == SC1 && dat[3]) mst = mst & 8'hF2;
    chk("cfgZero", m0, cfgZero_q);
    chk("cfgOne", m1, cfgOne_q);
  endtask

  task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
    hv(1'b0, sel, 8'h00);
    chk("dataPort", exp, dataPort_q);
    if (sel == SST) mst = mst & 8'hE9;
  endtask

  task automatic evt(input int n, input logic [7:0] setBits, input logic irq, input logic snap);
    repeat (n) @(negedge clk);
    mst = mst | setBits;
    chk("hvIrq", {7'h00, irq}, {7'h00, hvIrq_q});
    if (snap) chk("snapshot", mst, dataPort_q);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      $display("[ERR] runTime expected end seen hang");
      results();
    end
  end

  initial begin
    void'($urandom(1));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("drv", 8'h03, drv());
    chk("wake", 8'h01, wk());
    evt(1, 8'h00, 1'b0, 1'b0);
    rd(SST, mst);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'h0F;
      wr(SC1, d);
      chk("pullup", {7'h00, d[0]}, {7'h00, wakePullup_q});
      rd(SC1, m1);
    end
    // wake timeout on, then off with software release
    wr(SC1, 8'h00);
    wr(SC0, 8'h10);
    chk("wake", 8'h02, wk());
    repeat (WTO - 5) @(negedge clk);
    chk("wake", 8'h02, wk());
    repeat (10) @(negedge clk);
    chk("wake", 8'h01, wk());
    m0 = 8'h00;
    chk("cfgZero", m0, cfgZero_q);
    wr(SC1, 8'h02);
    wr(SC0, 8'h10);
    repeat (WTO + 10) @(negedge clk);
    chk("wake", 8'h02, wk());
    wr(SC0, 8'h00);
    chk("wake", 8'h01, wk());
    // pin edges with input capability on and off
    wr(SC1, 8'h10);
    extWake = 1'b1;
    evt(8, 8'h10, 1'b1, 1'b1);
    rd(SMN, 8'h80);
    rd(SST, mst);
    evt(2, 8'h00, 1'b0, 1'b0);
    extTest = 1'b1;
    evt(8, 8'h00, 1'b1, 1'b1);
    rd(SMN, 8'hA0);
    rd(SST, mst);
    wr(SC1, 8'h00);
    extWake = 1'b0;
    evt(8, 8'h00, 1'b0, 1'b0);
    rd(SMN, 8'h00);
    extTest = 1'b0;
    // a short below the persistence time is ignored
    fault = 5'h10;
    evt(300, 8'h00, 1'b0, 1'b0);
    fault = 5'h00;
    repeat (5) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      fault = k ? 5'h08 : 5'h10;
      evt(410, k ? 8'h02 : 8'h04, 1'b1, 1'b1);
      chk("drv", k ? 8'h02 : 8'h01, drv());
      fault = 5'h00;
      rd(SST, mst);
      evt(2, 8'h00, 1'b1, 1'b0);
      rd(SST, mst);
      wr(SC1, 8'h08);
      evt(2, 8'h00, 1'b0, 1'b0);
      chk("drv", 8'h03, drv());
    end
    wr(SC1, 8'h04);
    fault = 5'h10;
    evt(410, 8'h04, 1'b1, 1'b1);
    chk("drv", 8'h03, drv());
    fault = 5'h00;
    wr(SC1, 8'h0C);
    evt(2, 8'h00, 1'b0, 1'b0);
    rd(SST, mst);
    // wake driver short
    wr(SC1, 8'h02);
    wr(SC0, 8'h10);
    fault = 5'h04;
    evt(WSC + 8, 8'h01, 1'b1, 1'b1);
    chk("wake", 8'h01, wk());
    fault = 5'h00;
    rd(SST, mst);
    wr(SC0, 8'h00);
    wr(SC1, 8'h08);
    evt(2, 8'h00, 1'b0, 1'b0);
    rd(SST, mst);
    // thermal with shutdown active, then with shutdown turned off
    for (int k = 0; k < 2; k++) begin
      wr(SC0, k ? 8'h80 : 8'h00);
      fault = 5'h02;
      evt(8, 8'h08, 1'b1, 1'b1);
      chk("drv", k ? 8'h03 : 8'h00, drv());
      fault = 5'h00;
      rd(SST, mst);
      evt(2, 8'h00, 1'b0, 1'b0);
      rd(SST, mst);
      chk("drv", k ? 8'h03 : 8'h00, drv());
      wr(SC1, 8'h08);
      evt(2, 8'h00, 1'b0, 1'b0);
      chk("drv", 8'h03, drv());
    end
    // undervoltage is live and gated by its enable
    wr(SC0, 8'h08);
    fault = 5'h01;
    evt(8, 8'h20, 1'b1, 1'b1);
    rd(SMN, 8'h10);
    rd(SST, mst);
    fault = 5'h00;
    mst = 8'h00;
    evt(8, 8'h00, 1'b0, 1'b0);
    rd(SST, mst);
    wr(SC0, 8'h00);
    fault = 5'h01;
    evt(8, 8'h00, 1'b0, 1'b0);
    rd(SST, mst);
    fault = 5'h00;
    // mid-run reset with wake driven and pull-up on, the wake edge still in the synchroniser
    wr(SC1, 8'h11);
    wr(SC0, 8'h90);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    m0 = 8'h00;
    m1 = 8'h00;
    mst = 8'h00;
    @(negedge clk);
    chk("cfgZero", m0, cfgZero_q);
    chk("cfgOne", m1, cfgOne_q);
    chk("wake", 8'h01, wk());
    chk("drv", 8'h03, drv());
    chk("pullup", 8'h00, {7'h00, wakePullup_q});
    chk("hvIrq", 8'h00, {7'h00, hvIrq_q});
    chk("dataPort", 8'h00, dataPort_q);
    chk("busy", 8'h00, {7'h00, cmdBusy_q});
    rd(SST, mst);
    results();
  end
endmodule
